// >>> hw/adc_control_result_regs.v
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "adc_control_map.vh"
module adc_control_result_regs #(
    parameter CONV_TICKS = 11
) (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // System events
    input wire special_trigger,
    input wire sleep_req,
    input wire rc_tick,
    // Converter core
    input wire [9:0] core_result,
    output reg core_power,
    output reg core_convert,
    output reg conv_tick,
    output reg [13:0] analog_input_select,
    output reg select_comparator_voltage_reference,
    output reg select_fixed_ref,
    output reg neg_reference_select,
    output reg pos_reference_select,
    // Completion event
    output reg conversion_done
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [7:0] control_main_reg;
    reg [7:0] format_ref_reg;
    reg [7:0] result_high_reg;
    reg [7:0] result_low_reg;
    reg busy_reg;
    reg [4:0] tick_count_reg;
    wire [3:0] channel_select;
    wire [1:0] conversion_clock_select;
    wire converter_enable;
    wire result_justify_select;
    wire bus_req;
    wire wr_main;
    wire wr_fmt;
    wire wr_high;
    wire wr_low;
    wire tick;
    wire finish;
    wire abort;

    assign channel_select = control_main_reg[5:2];
    assign conversion_clock_select = control_main_reg[7:6];
    assign converter_enable = control_main_reg[`ADC_BIT_ENABLE];
    assign result_justify_select = format_ref_reg[`ADC_BIT_JUSTIFY];
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_main = bus_req && wb_we_i && wb_sel_i[0] &&
                     wb_adr_i == `ADC_OFS_CONTROL_MAIN;
    assign wr_fmt = bus_req && wb_we_i && wb_sel_i[0] &&
                    wb_adr_i == `ADC_OFS_CONTROL_FORMAT_REF;
    assign wr_high = bus_req && wb_we_i && wb_sel_i[0] &&
                     wb_adr_i == `ADC_OFS_RESULT_HIGH;
    assign wr_low = bus_req && wb_we_i && wb_sel_i[0] &&
                    wb_adr_i == `ADC_OFS_RESULT_LOW;

    // ------------------------------------------------------------
    // Conversion sequencing
    // ------------------------------------------------------------
    adc_conv_clock u_clk (
        .mclk(mclk),
        .srst(srst),
        .run(busy_reg),
        .conversion_clock_select(conversion_clock_select),
        .rc_tick(rc_tick),
        .tick(tick)
    );
    assign finish = busy_reg && tick && tick_count_reg == CONV_TICKS[4:0] - 5'h01;
    assign abort = busy_reg && sleep_req && conversion_clock_select != `ADC_CLKSEL_RC;

    always @(posedge mclk) begin
        if (srst) begin
            control_main_reg <= `ADC_RESET_CONTROL_MAIN;
            format_ref_reg <= `ADC_RESET_CONTROL_FORMAT_REF;
            busy_reg <= 1'b0;
            tick_count_reg <= 5'h00;
            conversion_done <= 1'b0;
        end else begin
            conversion_done <= finish;
            if (wr_main) begin
                control_main_reg <= {wb_dat_i[7:2], 1'b0, wb_dat_i[0]};
            end
            if (wr_fmt) begin
                format_ref_reg <= wb_dat_i[7:0] & `ADC_FORMAT_WMASK;
            end
            if (finish || abort) begin
                busy_reg <= 1'b0;
                tick_count_reg <= 5'h00;
            end else if (!busy_reg && converter_enable &&
                         ((wr_main && wb_dat_i[`ADC_BIT_GO]) || special_trigger)) begin
                busy_reg <= 1'b1;
                tick_count_reg <= 5'h00;
            end else if (busy_reg && tick) begin
                tick_count_reg <= tick_count_reg + 5'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (srst) begin
            result_high_reg <= `ADC_RESET_RESULT;
            result_low_reg <= `ADC_RESET_RESULT;
        end else if (finish) begin
            if (result_justify_select) begin
                result_high_reg <= {6'h00, core_result[9:8]};
                result_low_reg <= core_result[7:0];
            end else begin
                result_high_reg <= core_result[9:2];
                result_low_reg <= {core_result[1:0], 6'h00};
            end
        end else begin
            if (wr_high) begin
                result_high_reg <= wb_dat_i[7:0];
            end
            if (wr_low) begin
                result_low_reg <= wb_dat_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Core and mux outputs
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (srst) begin
            core_power <= 1'b0;
            core_convert <= 1'b0;
            conv_tick <= 1'b0;
            analog_input_select <= 14'h0000;
            select_comparator_voltage_reference <= 1'b0;
            select_fixed_ref <= 1'b0;
            neg_reference_select <= 1'b0;
            pos_reference_select <= 1'b0;
        end else begin
            // power gating; a sleep abort drops power until sleep ends
            core_power <= converter_enable && !(sleep_req &&
                          conversion_clock_select != `ADC_CLKSEL_RC);
            core_convert <= busy_reg && !finish && !abort;
            conv_tick <= tick;
            analog_input_select <= (channel_select <= 4'hd) ?
                                   (14'h0001 << channel_select) : 14'h0000;
            select_comparator_voltage_reference <= channel_select == 4'he;
            select_fixed_ref <= channel_select == 4'hf;
            neg_reference_select <= format_ref_reg[`ADC_BIT_NEG_REF];
            pos_reference_select <= format_ref_reg[`ADC_BIT_POS_REF];
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    `ADC_OFS_CONTROL_MAIN: wb_dat_o <= {24'h000000,
                        control_main_reg[7:2], busy_reg, control_main_reg[0]};
                    `ADC_OFS_CONTROL_FORMAT_REF: wb_dat_o <= {24'h000000, format_ref_reg};
                    `ADC_OFS_RESULT_HIGH: wb_dat_o <= {24'h000000, result_high_reg};
                    `ADC_OFS_RESULT_LOW: wb_dat_o <= {24'h000000, result_low_reg};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // adc_control_result_regs
`default_nettype wire

// >>> hw/adc_control_map.vh
// What this block does
// - Channel codes 1000-1101 pick inputs 8-13; 1110 comparator reference, 1111 fixed 0.6 V.
// - Writing one to control bit 1 starts a conversion.
// - Hardware clears the status bit when the conversion finishes.
// - Status bit reads one while converting, zero otherwise.
// - Control bit 0 enables the converter; zero keeps it powered down.
// - Format bit 7: one right justified, zero left justified result.
// - Format bit 5: one external negative reference, zero ground.
// - Format bit 4: one external positive reference, zero supply.
// - Format bits 6 and 3-0 ignore writes and read zero.
// - Left justified: result bits 9-2 fill the high result register.
// - Left justified: result bits 1-0 in low bits 7-6; rest reserved.
// - Right justified: result bits 9-8 in high register bits 1-0.
// - Right justified: result bits 7-0 fill the low result register.
// - Control bits 7-6 pick conversion clock: /2, /8, /32, internal RC.
// - Channel codes 0000-0111 pick analog inputs 0-7.
// - A trigger from the capture/compare unit sets status and starts conversion.
// - Sleep aborts a non-RC conversion and powers off, enable stays set.
`ifndef ADC_CONTROL_MAP_VH
`define ADC_CONTROL_MAP_VH
`define ADC_OFS_CONTROL_MAIN 4'h0
`define ADC_OFS_CONTROL_FORMAT_REF 4'h4
`define ADC_OFS_RESULT_HIGH 4'h8
`define ADC_OFS_RESULT_LOW 4'hc
`define ADC_BIT_ENABLE 0
`define ADC_BIT_GO 1
`define ADC_BIT_JUSTIFY 7
`define ADC_BIT_NEG_REF 5
`define ADC_BIT_POS_REF 4
`define ADC_FORMAT_WMASK 8'hb0
`define ADC_RESET_CONTROL_MAIN 8'h00
`define ADC_RESET_CONTROL_FORMAT_REF 8'h00
`define ADC_RESET_RESULT 8'h00
`define ADC_CLKSEL_DIV2 2'h0
`define ADC_CLKSEL_DIV8 2'h1
`define ADC_CLKSEL_DIV32 2'h2
`define ADC_CLKSEL_RC 2'h3
`define ADC_DIV2_CYCLES 6'h01
`define ADC_DIV8_CYCLES 6'h07
`define ADC_DIV32_CYCLES 6'h1f
`endif

// >>> hw/adc_conv_clock.v
`timescale 1ns/1ps
`default_nettype none
`include "adc_control_map.vh"
module adc_conv_clock (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Control
    input wire run,
    input wire [1:0] conversion_clock_select,
    input wire rc_tick,
    // Conversion clock enable
    output reg tick
);
    reg [5:0] count_reg;
    reg [5:0] limit;
    always @* begin
        case (conversion_clock_select)
            `ADC_CLKSEL_DIV2: limit = `ADC_DIV2_CYCLES;
            `ADC_CLKSEL_DIV8: limit = `ADC_DIV8_CYCLES;
            default: limit = `ADC_DIV32_CYCLES;
        endcase
    end
    always @(posedge mclk) begin
        if (srst || !run) begin
            count_reg <= 6'h00;
            tick <= 1'b0;
        end else if (conversion_clock_select == `ADC_CLKSEL_RC) begin
            count_reg <= 6'h00;
            tick <= rc_tick;
        end else if (count_reg >= limit) begin
            count_reg <= 6'h00;
            tick <= 1'b1;
        end else begin
            count_reg <= count_reg + 6'h01;
            tick <= 1'b0;
        end
    end
endmodule // adc_conv_clock
`default_nettype wire

// >>> test/adc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
    // Core side
    input wire logic mclk,
    input wire logic core_power,
    input wire logic core_convert,
    input wire logic [9:0] core_value,
    output logic [9:0] core_result
);
    initial core_result = 10'h155;
    // Outside a conversion the output keeps toggling, so a stale sample is seen
    always @(posedge mclk) core_result <= (core_power && core_convert) ? core_value : ~core_result;
endmodule // adc_core_model
`default_nettype wire

// >>> test/adc_control_result_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module adc_regs_checker #(
    parameter CONV_TICKS = 11
) (
    // Clock, reset and bus
    input wire logic mclk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Converter side
    input wire logic sleep_req,
    input wire logic core_power,
    input wire logic core_convert,
    input wire logic [13:0] analog_input_select,
    input wire logic select_comparator_voltage_reference,
    input wire logic select_fixed_ref,
    input wire logic neg_reference_select,
    input wire logic pos_reference_select,
    input wire logic conversion_done
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    chk_done_pulse: assert property (conversion_done |=> !conversion_done)
        else $error("done pulse too long");
    chk_done_cause: assert property (conversion_done |-> $past(core_convert) && !core_convert)
        else $error("done without end of conversion");
    chk_select_onehot: assert property ($onehot0({analog_input_select, select_comparator_voltage_reference, select_fixed_ref}))
        else $error("input select not one-hot");
    chk_convert_span: assert property ($rose(core_convert) && !sleep_req |-> (core_power && core_convert) [*4])
        else $error("conversion too short or unpowered");
    chk_ref_cause: assert property ($changed({neg_reference_select, pos_reference_select}) |-> $past(wb_we_i) || $past(wb_we_i, 2))
        else $error("reference select moved without write");
endmodule // adc_regs_checker
bind adc_control_result_regs adc_regs_checker #(.CONV_TICKS(CONV_TICKS)) checker_i (
    .mclk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .sleep_req, .core_power,
    .core_convert, .analog_input_select, .select_comparator_voltage_reference, .select_fixed_ref, .neg_reference_select,
    .pos_reference_select, .conversion_done);
`default_nettype wire

// >>> test/adc_control_result_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_control_result_regs_bench;
    logic mclk = 1'b0, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic special_trigger = 1'b0, sleep_req = 1'b0, rc_tick = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [9:0] core_value = 10'h0;
    logic [7:0] q;
    wire [31:0] wb_dat_o;
    wire [13:0] analog_input_select;
    wire [9:0] core_result;
    wire wb_ack_o, core_power, core_convert, conv_tick, select_comparator_voltage_reference, select_fixed_ref;
    wire neg_reference_select, pos_reference_select, conversion_done;
    localparam int TICKS = 3;
    int failures = 0, tests_run = 0, done_count = 0, conv_cycles = 0, tick_total = 0;
    logic [19:0] rows [7] = '{20'h4ffb0, 20'h44f00, 20'h8a5a5, 20'hc3c3c, 20'h0fcfc, 20'h00200, 20'h2ff00};
    always #5 mclk = ~mclk;
    always @(posedge mclk) rc_tick <= !rc_tick;
    // Event counters: done pulses, cycles spent converting, conversion clock pulses
    always @(posedge mclk) begin
        done_count <= done_count + (conversion_done === 1'b1);
        conv_cycles <= conv_cycles + (core_convert === 1'b1);
        tick_total <= tick_total + (conv_tick === 1'b1);
    end
    adc_control_result_regs #(.CONV_TICKS(TICKS)) DUT (.mclk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .special_trigger, .sleep_req, .rc_tick,
        .core_result, .core_power, .core_convert, .conv_tick, .analog_input_select, .select_comparator_voltage_reference,
        .select_fixed_ref, .neg_reference_select, .pos_reference_select, .conversion_done);
    adc_core_model core_i (.mclk, .core_power, .core_convert, .core_value, .core_result);
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
        @(posedge mclk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 24'h0, d};
        // Only the watchdog ends a wait that never sees ack
        do @(posedge mclk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        bus(a, 1'b0, 8'h00);
        cmp({24'h0, q & m}, {24'h0, e});
    endtask
    task automatic conv(input logic [1:0] cs, input logic j, input logic [9:0] v, input logic trig);
        int n, d0, c0, t0;
        n = 0;
        d0 = done_count;
        c0 = conv_cycles;
        t0 = tick_total;
        core_value <= v;
        bus(4'h4, 1'b1, {j, 7'h00});
        // Go is refused while disabled, so enable first
        bus(4'h0, 1'b1, {cs, 4'h0, 1'b0, 1'b1});
        if (!trig) bus(4'h0, 1'b1, {cs, 4'h0, 2'b11});
        special_trigger <= trig;
        @(posedge mclk) special_trigger <= 1'b0;
        rd(4'h0, 8'h02, 8'h02);
        do bus(4'h0, 1'b0, 8'h00); while (q[1] && ++n < 100);
        cmp({31'h0, q[1]}, 32'h0);
        rd(4'h8, j ? {6'h0, v[9:8]} : v[9:2], j ? 8'h03 : 8'hff);
        rd(4'hc, j ? v[7:0] : {v[1:0], 6'h0}, j ? 8'hff : 8'hc0);
        cmp(32'(done_count - d0), 32'h1);
        cmp(32'(tick_total - t0), 32'(TICKS));
        if (cs != 2'h3) cmp(32'(conv_cycles - c0), 32'(TICKS << (2 * cs + 1)));
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        for (int a = 0; a < 16; a += 4) rd(4'(a), 8'h00, 8'hff);
        foreach (rows[i]) begin
            bus(rows[i][19:16], 1'b1, rows[i][15:8]);
            rd(rows[i][19:16], rows[i][7:0], 8'hff);
        end
        // A write without byte lane 0 is acknowledged but dropped
        wb_sel_i <= 4'he;
        bus(4'h4, 1'b1, 8'hb0);
        wb_sel_i <= 4'hf;
        rd(4'h4, 8'h00, 8'hff);
        for (int c = 0; c < 16; c++) begin
            bus(4'h0, 1'b1, {2'b00, 4'(c), 2'b00});
            repeat (2) @(posedge mclk);
            cmp(32'({analog_input_select, select_comparator_voltage_reference, select_fixed_ref}),
                c < 14 ? 32'h4 << c : 32'h10 - c);
        end
        for (int r = 1; r < 3; r++) begin
            bus(4'h4, 1'b1, 8'(r << 4));
            repeat (2) @(posedge mclk);
            cmp({30'h0, neg_reference_select, pos_reference_select}, 32'(r));
        end
        for (int k = 0; k < 8; k++) conv(2'(k >> 1), k[0], 10'h2c5 ^ 10'(k * 73), 1'b0);
        conv(2'h2, 1'b1, 10'h3a6, 1'b1);
        bus(4'h0, 1'b1, 8'h83);
        sleep_req <= 1'b1;
        repeat (4) @(posedge mclk);
        cmp({31'h0, core_power}, 32'h0);
        rd(4'h0, 8'h81, 8'hff);
        sleep_req <= 1'b0;
        repeat (4) @(posedge mclk);
        cmp({31'h0, core_power}, 32'h1);
        bus(4'h0, 1'b1, 8'h00);
        repeat (2) @(posedge mclk);
        cmp({31'h0, core_power}, 32'h0);
        final_report();
    end
    initial begin
        #100us;
        failures++;
        final_report();
    end
endmodule // adc_control_result_regs_bench
`default_nettype wire
